// ### fsp_defines.vh
// Purpose: Shared constants of the flash status and protection block
// Assumes: Included by bare name from the design file
// Notes: Definitions only
`ifndef FSP_DEFINES_VH
`define FSP_DEFINES_VH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define FSP_CMD_LATCH_SET 8'h06
`define FSP_CMD_LATCH_CLR 8'h04
`define FSP_CMD_STAT_RD 8'h05
`define FSP_CMD_STAT2_RD 8'h09
`define FSP_CMD_STAT_WR 8'h01
`define FSP_CMD_OTP_ENTER 8'h3A
`define FSP_CMD_PAGE_WR 8'h02
`define FSP_CMD_QPAGE_WR 8'h32
`define FSP_CMD_WIPE_4K 8'h20
`define FSP_CMD_WIPE_BLK 8'hD8
`define FSP_CMD_WIPE_ALL 8'hC7

// ----------------------------------------------------------------
// Status byte bit positions (both views)
// ----------------------------------------------------------------
`define FSP_BIT_BUSY 0
`define FSP_BIT_UNLOCK 1
`define FSP_BIT_PROT_LO 2
`define FSP_BIT_PROT_HI 5
`define FSP_BIT_BOOT_EN 6
`define FSP_BIT_STAT_LOCK 7
`define FSP_BIT_ANCHOR 3
`define FSP_BIT_GRAN 4
`define FSP_BIT_PSEL 5
`define FSP_BIT_PFD 6
`define FSP_BIT_OTP_LOCK 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FSP_RST_PROT 4'h0
`define FSP_RST_PFD 1'b1
`define FSP_RST_BIT 1'b0

// ----------------------------------------------------------------
// Frame lengths in serial clock edges
// ----------------------------------------------------------------
`define FSP_LEN_OP 6'h08
`define FSP_LEN_SW 6'h10
`define FSP_LEN_ADDR 6'h20
`define FSP_LEN_PAGE_MIN 6'h28

// ----------------------------------------------------------------
// Array operation kinds
// ----------------------------------------------------------------
`define FSP_OP_STAT 3'h0
`define FSP_OP_PAGE 3'h1
`define FSP_OP_4K 3'h2
`define FSP_OP_BLK 3'h3
`define FSP_OP_ALL 3'h4

`endif

// ### fsp_status_protect.v
// Purpose: Status byte, write latch and write protection of a serial flash
// Assumes: SPI mode 0 link sampled by sys_clk; link clock well below sys_clk/4
// Notes: Array engine is outside; this block starts it and times its busy window
//
// Overview of operation
// (RULE_01) Busy flag at bit 0 high while status write, program or erase runs.
// (RULE_02) Write latch shown at bit 1; writes refused while it is clear.
// (RULE_03) Four protection level bits 5..2 written by status write select shielded size.
// (RULE_04) Nonzero protection level refuses page writes and wipes into the shielded region.
// (RULE_05) Whole array wipe only when protection level and boot lock are zero.
// (RULE_06) Boot lock at bit 6 locks the top or bottom sector or block.
// (RULE_07) Status lock plus low write guard pin freezes bits 7,5..2, refuses status write; code still accepts status writes in OTP mode.
// (RULE_08) Write guard pin ignored until pin function disable is cleared; default set.
// (RULE_09) OTP mode remaps bits 7..3, bit 2 reserved, bits 1,0 unchanged.
// (RULE_10) Top/bottom select anchors region at top when 0, bottom when 1.
// (RULE_11) Boot lock granule selects 64KB block when 0, 4KB sector when 1.
// (RULE_12) Pin function disable turns guard and pause/restart pin off; quad use also.
// (RULE_13) Pin select makes shared pin pause when 0, restart when 1.
// (RULE_14) OTP lock, once set, blocks OTP sector program and erase forever.
// (RULE_15) Busy bit read by status read equals busy bit of second status byte.
// (RULE_16) Latch set command, framed alone, sets the write latch.
// (RULE_17) Latch clear command clears latch and leaves OTP mode.
// (RULE_18) Latch cleared at power-up and at end of each write operation.
// (RULE_19) Bit 2 reads zero in OTP mode and writes to it are ignored.
// (RULE_20) Status write never changes busy or latch indicator bits.
`timescale 1ns/1ps
`include "fsp_defines.vh"

module fsp_status_protect #(
  parameter OP_CYCLES = 64,
  parameter BLK_BITS = 7
) (
  input wire sys_clk,
  input wire resetn,
  input wire spi_clk,
  input wire spi_cs_n,
  input wire spi_mosi,
  input wire write_guard_pin,
  input wire shared_ctl_pin,
  output reg spi_miso_reg,
  output reg spi_miso_oe_reg,
  output reg write_busy_reg,
  output reg array_start_reg,
  output reg [2:0] array_kind_reg,
  output reg array_otp_reg,
  output reg [23:0] array_addr_reg,
  output reg pause_active_reg,
  output reg hw_restart_reg
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [1:0] clk_sync_reg;
  reg [1:0] cs_sync_reg;
  reg [1:0] mosi_sync_reg;
  reg [1:0] wp_sync_reg;
  reg [1:0] pin_sync_reg;
  reg clk_prev_reg;
  reg cs_prev_reg;

  // Two flops per pin; only the second stage feeds any logic
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clk_sync_reg <= 2'h0;
      cs_sync_reg <= 2'h3;
      mosi_sync_reg <= 2'h0;
      wp_sync_reg <= 2'h3;
      pin_sync_reg <= 2'h3;
      clk_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      clk_sync_reg <= {clk_sync_reg[0], spi_clk};
      cs_sync_reg <= {cs_sync_reg[0], spi_cs_n};
      mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi};
      wp_sync_reg <= {wp_sync_reg[0], write_guard_pin};
      pin_sync_reg <= {pin_sync_reg[0], shared_ctl_pin};
      clk_prev_reg <= clk_sync_reg[1];
      cs_prev_reg <= cs_sync_reg[1];
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg unlock_reg;
  reg otp_mode_reg;
  reg stat_lock_reg;
  reg boot_en_reg;
  reg [3:0] prot_reg;
  reg otp_lock_reg;
  reg pfd_reg;
  reg psel_reg;
  reg gran_reg;
  reg bottom_reg;
  reg quad_used_reg;
  reg [15:0] busy_cnt_reg;
  reg [7:0] cmd_reg;
  reg [7:0] rx_reg;
  reg [23:0] addr_reg;
  reg [5:0] bit_cnt_reg;
  reg [7:0] tx_reg;

  // ----------------------------------------------------------------
  // Derived terms
  // ----------------------------------------------------------------
  wire pins_on = !pfd_reg && !quad_used_reg;                  // see (RULE_08) see (RULE_12)
  wire hw_guard = stat_lock_reg && !wp_sync_reg[1] && pins_on;  // see (RULE_07)
  wire paused = pause_active_reg;
  wire frame = !cs_sync_reg[1];
  wire sclk_rise = frame && !paused && clk_sync_reg[1] && !clk_prev_reg;
  wire sclk_fall = frame && !paused && !clk_sync_reg[1] && clk_prev_reg;
  wire frame_end = cs_sync_reg[1] && !cs_prev_reg;
  wire [7:0] rx_next = {rx_reg[6:0], mosi_sync_reg[1]};
  wire [7:0] cmd_next = (bit_cnt_reg == 6'h07) ? rx_next : cmd_reg;
  wire [7:0] sw_data = addr_reg[7:0];
  wire is_read = (cmd_next == `FSP_CMD_STAT_RD) || (cmd_next == `FSP_CMD_STAT2_RD);

  // Status byte as seen in the current view
  wire [7:0] stat_normal = {stat_lock_reg, boot_en_reg, prot_reg, unlock_reg,
                            write_busy_reg};
  wire [7:0] stat_otp = {otp_lock_reg, pfd_reg, psel_reg, gran_reg, bottom_reg,
                         1'b0, unlock_reg, write_busy_reg};       // see (RULE_09) see (RULE_19)
  wire [7:0] stat_view = otp_mode_reg ? stat_otp : stat_normal;
  wire [7:0] stat_two = {7'h00, write_busy_reg};                 // see (RULE_15)

  // ----------------------------------------------------------------
  // Protection functions
  // ----------------------------------------------------------------
  // Shielded area grows in powers of two of 64KB blocks from the anchor end
  function level_hit;
    input [3:0] level;
    input bot;
    input [BLK_BITS-1:0] blk;
    reg [BLK_BITS:0] span;
    begin
      span = (level >= 4'h8) ? {1'b1, {BLK_BITS{1'b0}}} :
             ({{BLK_BITS{1'b0}}, 1'b1} << (level - 4'h1));
      if (level == 4'h0)
        level_hit = 1'b0;
      else if (bot)
        level_hit = ({1'b0, blk} < span);
      else
        level_hit = ({1'b0, blk} >= ({1'b1, {BLK_BITS{1'b0}}} - span));
    end
  endfunction

  // Boot unit is the end block, or the end sector when the granule is 4KB
  function boot_hit;
    input en;
    input gran;
    input bot;
    input whole_blk;
    input [BLK_BITS+3:0] sec;
    begin
      if (!en)
        boot_hit = 1'b0;
      else if (gran && !whole_blk)
        boot_hit = bot ? (sec == {(BLK_BITS+4){1'b0}}) : (sec == {(BLK_BITS+4){1'b1}});
      else
        boot_hit = bot ? (sec[BLK_BITS+3:4] == {BLK_BITS{1'b0}}) :
                        (sec[BLK_BITS+3:4] == {BLK_BITS{1'b1}});
    end
  endfunction

  wire whole_blk = (cmd_reg == `FSP_CMD_WIPE_BLK);
  wire main_blocked = level_hit(prot_reg, bottom_reg, addr_reg[BLK_BITS+15:16]) || // see (RULE_04)
                      boot_hit(boot_en_reg, gran_reg, bottom_reg, whole_blk,
                               addr_reg[BLK_BITS+15:12]);                      // see (RULE_06) see (RULE_10) see (RULE_11)
  wire target_blocked = otp_mode_reg ? otp_lock_reg : main_blocked;           // see (RULE_14)

  // ----------------------------------------------------------------
  // Serial shifter: capture on rising, drive on falling
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_reg <= 8'h00;
      cmd_reg <= 8'h00;
      addr_reg <= 24'h000000;
      bit_cnt_reg <= 6'h00;
      tx_reg <= 8'h00;
      spi_miso_reg <= 1'b0;
      spi_miso_oe_reg <= 1'b0;
    end else if (!frame || hw_restart_reg) begin
      bit_cnt_reg <= 6'h00;
      spi_miso_oe_reg <= 1'b0;
    end else begin
      if (sclk_rise) begin
        rx_reg <= rx_next;
        if (bit_cnt_reg != 6'h3F)
          bit_cnt_reg <= bit_cnt_reg + 6'h01;
        if (bit_cnt_reg == 6'h07)
          cmd_reg <= rx_next;
        if (bit_cnt_reg >= 6'h08 && bit_cnt_reg < 6'h20)
          addr_reg <= {addr_reg[22:0], mosi_sync_reg[1]};
        // Reload every byte so the status can be polled for seven bytes in one frame
        if (bit_cnt_reg[2:0] == 3'h7 && is_read) begin
          tx_reg <= (cmd_next == `FSP_CMD_STAT2_RD) ? stat_two : stat_view;   // see (RULE_15)
          spi_miso_oe_reg <= 1'b1;
        end
      end
      if (sclk_fall && spi_miso_oe_reg) begin
        spi_miso_reg <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin functions
  // ----------------------------------------------------------------
  // Shared pin is pause or restart only while pin functions are enabled
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pause_active_reg <= 1'b0;
      hw_restart_reg <= 1'b0;
    end else begin
      pause_active_reg <= pins_on && !psel_reg && !pin_sync_reg[1];   // see (RULE_13)
      hw_restart_reg <= pins_on && psel_reg && !pin_sync_reg[1];      // see (RULE_13)
    end
  end

  // ----------------------------------------------------------------
  // Command execution at the end of each frame
  // ----------------------------------------------------------------
  // Everything is decided on chip select rising so a cut-short frame does nothing but mark quad use
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      unlock_reg <= `FSP_RST_BIT;                                     // see (RULE_18)
      otp_mode_reg <= `FSP_RST_BIT;
      stat_lock_reg <= `FSP_RST_BIT;
      boot_en_reg <= `FSP_RST_BIT;
      prot_reg <= `FSP_RST_PROT;
      otp_lock_reg <= `FSP_RST_BIT;
      pfd_reg <= `FSP_RST_PFD;                                        // see (RULE_08)
      psel_reg <= `FSP_RST_BIT;
      gran_reg <= `FSP_RST_BIT;
      bottom_reg <= `FSP_RST_BIT;
      quad_used_reg <= `FSP_RST_BIT;
      write_busy_reg <= `FSP_RST_BIT;
      busy_cnt_reg <= 16'h0000;
      array_start_reg <= 1'b0;
      array_kind_reg <= `FSP_OP_STAT;
      array_otp_reg <= 1'b0;
      array_addr_reg <= 24'h000000;
    end else begin
      array_start_reg <= 1'b0;
      if (hw_restart_reg) begin
        // Restart drops volatile state and abandons any running operation
        unlock_reg <= 1'b0;
        otp_mode_reg <= 1'b0;
        write_busy_reg <= 1'b0;
        busy_cnt_reg <= 16'h0000;
      end else if (write_busy_reg) begin
        // Only reads are served while busy; end of operation drops the latch
        if (busy_cnt_reg == 16'h0001) begin
          write_busy_reg <= 1'b0;                                      // see (RULE_01)
          unlock_reg <= 1'b0;                                          // see (RULE_18)
        end
        busy_cnt_reg <= busy_cnt_reg - 16'h0001;
      end else if (frame_end) begin
        case (cmd_reg)
          `FSP_CMD_LATCH_SET: begin
            if (bit_cnt_reg == `FSP_LEN_OP)
              unlock_reg <= 1'b1;                                      // see (RULE_16)
          end
          `FSP_CMD_LATCH_CLR: begin
            if (bit_cnt_reg == `FSP_LEN_OP) begin
              unlock_reg <= 1'b0;                                      // see (RULE_17)
              otp_mode_reg <= 1'b0;
            end
          end
          `FSP_CMD_OTP_ENTER: begin
            if (bit_cnt_reg == `FSP_LEN_OP)
              otp_mode_reg <= 1'b1;
          end
          `FSP_CMD_STAT_WR: begin
            // Bits 1 and 0 of the written byte are never used
            if (bit_cnt_reg == `FSP_LEN_SW && unlock_reg) begin        // see (RULE_02) see (RULE_20)
              if (otp_mode_reg) begin
                otp_lock_reg <= otp_lock_reg | sw_data[`FSP_BIT_OTP_LOCK];   // see (RULE_14)
                pfd_reg <= sw_data[`FSP_BIT_PFD];                      // see (RULE_12)
                psel_reg <= sw_data[`FSP_BIT_PSEL];
                gran_reg <= sw_data[`FSP_BIT_GRAN];                    // see (RULE_11)
                bottom_reg <= sw_data[`FSP_BIT_ANCHOR];                // see (RULE_10)
                write_busy_reg <= 1'b1;
                busy_cnt_reg <= OP_CYCLES[15:0];
              end else if (!hw_guard) begin                            // see (RULE_07)
                stat_lock_reg <= sw_data[`FSP_BIT_STAT_LOCK];
                boot_en_reg <= sw_data[`FSP_BIT_BOOT_EN];
                prot_reg <= sw_data[`FSP_BIT_PROT_HI:`FSP_BIT_PROT_LO];  // see (RULE_03)
                write_busy_reg <= 1'b1;                                // see (RULE_01)
                busy_cnt_reg <= OP_CYCLES[15:0];
              end
            end
          end
          `FSP_CMD_PAGE_WR, `FSP_CMD_QPAGE_WR: begin
            if (cmd_reg == `FSP_CMD_QPAGE_WR)
              quad_used_reg <= 1'b1;                                   // see (RULE_12)
            if (bit_cnt_reg >= `FSP_LEN_PAGE_MIN && unlock_reg && !target_blocked) begin
              write_busy_reg <= 1'b1;                                  // see (RULE_01)
              busy_cnt_reg <= OP_CYCLES[15:0];
              array_start_reg <= 1'b1;
              array_kind_reg <= `FSP_OP_PAGE;
              array_otp_reg <= otp_mode_reg;
              array_addr_reg <= addr_reg;
            end
          end
          `FSP_CMD_WIPE_4K, `FSP_CMD_WIPE_BLK: begin
            if (bit_cnt_reg == `FSP_LEN_ADDR && unlock_reg && !target_blocked) begin  // see (RULE_04)
              write_busy_reg <= 1'b1;
              busy_cnt_reg <= OP_CYCLES[15:0];
              array_start_reg <= 1'b1;
              array_kind_reg <= whole_blk ? `FSP_OP_BLK : `FSP_OP_4K;
              array_otp_reg <= otp_mode_reg;
              array_addr_reg <= addr_reg;
            end
          end
          `FSP_CMD_WIPE_ALL: begin
            if (bit_cnt_reg == `FSP_LEN_OP && unlock_reg && !otp_mode_reg &&
                prot_reg == 4'h0 && !boot_en_reg) begin                // see (RULE_05)
              write_busy_reg <= 1'b1;
              busy_cnt_reg <= OP_CYCLES[15:0];
              array_start_reg <= 1'b1;
              array_kind_reg <= `FSP_OP_ALL;
              array_otp_reg <= 1'b0;
              array_addr_reg <= 24'h000000;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule // fsp_status_protect

// ### fsp_host_model.sv
// Purpose: Host SPI controller model driving mode 0 frames
// Assumes: Link clock half period is four sys_clk cycles (64 ns period)
// Notes: Link clock stands low between frames; data line inverted once released
`timescale 1ns/1ps
module fsp_host_model (
  input wire sys_clk,
  input wire miso,
  output reg sclk,
  output reg cs_n,
  output reg mosi
);
  // ------------------------------------------------------------
  // Frame driver
  // ------------------------------------------------------------
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // MSB first; miso taken late in the high phase to clear the output lag
  task xfer(input [47:0] d, input integer n, output [7:0] rd);
    integer i;
    begin
      rd = 8'h00;
      @(posedge sys_clk) #1;
      cs_n = 1'b0;
      for (i = n - 1; i >= 0; i = i - 1) begin
        mosi = d[i];
        repeat (4) @(posedge sys_clk) #1;
        sclk = 1'b1;
        repeat (4) @(posedge sys_clk);
        rd = {rd[6:0], miso};
        #1 sclk = 1'b0;
      end
      repeat (4) @(posedge sys_clk) #1;
      cs_n = 1'b1; // Frame closes the command alone
      mosi = ~mosi; // Released line no longer shows the last bit
      repeat (8) @(posedge sys_clk) #1;
    end
  endtask
endmodule // fsp_host_model

// ### fsp_status_protect_props.sv
// Purpose: Port-level checks of the flash status and protection block
// Assumes: Single sys_clk domain, resetn asynchronous active low
// Notes: Busy length measured by a helper counter
`timescale 1ns/1ps
module fsp_status_protect_props #(
  parameter OP_CYCLES = 64,
  parameter BLK_BITS = 7
) (
  input wire sys_clk,
  input wire resetn,
  input wire spi_clk,
  input wire spi_cs_n,
  input wire spi_mosi,
  input wire write_guard_pin,
  input wire shared_ctl_pin,
  input wire spi_miso_reg,
  input wire spi_miso_oe_reg,
  input wire write_busy_reg,
  input wire array_start_reg,
  input wire [2:0] array_kind_reg,
  input wire array_otp_reg,
  input wire [23:0] array_addr_reg,
  input wire pause_active_reg,
  input wire hw_restart_reg
);
  // ------------------------------------------------------------
  // Helper logic and properties
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  reg [15:0] busy_cnt_reg;
  // Counts cycles of one busy window; restart may cut it short
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy_cnt_reg <= 16'h0000;
    end else if (!write_busy_reg) begin
      busy_cnt_reg <= 16'h0000;
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 16'h0001;
    end
  end
  busy_length_a: assert property ($fell(write_busy_reg) && !hw_restart_reg &&
    !$past(hw_restart_reg) |-> busy_cnt_reg == OP_CYCLES) else $error("busy length wrong");
  start_busy_a: assert property (array_start_reg |-> $rose(write_busy_reg))
    else $error("start without busy");
  start_pulse_a: assert property (array_start_reg |=> !array_start_reg)
    else $error("start longer than one cycle");
  start_kind_a: assert property (array_start_reg |->
    array_kind_reg >= 3'h1 && array_kind_reg <= 3'h4) else $error("bad kind");
  busy_frame_a: assert property ($rose(write_busy_reg) |->
    spi_cs_n && $past(spi_cs_n)) else $error("busy inside frame");
  pin_idle_a: assert property (shared_ctl_pin [*4] |->
    !pause_active_reg && !hw_restart_reg) else $error("pin function without pin");
  pin_excl_a: assert property (!(pause_active_reg && hw_restart_reg))
    else $error("pause and restart together");
  restart_busy_a: assert property (hw_restart_reg [*3] |-> !write_busy_reg)
    else $error("busy through restart");
  oe_frame_a: assert property (spi_cs_n [*4] |-> !spi_miso_oe_reg)
    else $error("miso driven outside frame");
endmodule // fsp_status_protect_props

bind fsp_status_protect fsp_status_protect_props #(.OP_CYCLES(OP_CYCLES), .BLK_BITS(BLK_BITS))
  u_props (.sys_clk(sys_clk), .resetn(resetn), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
  .spi_mosi(spi_mosi), .write_guard_pin(write_guard_pin), .shared_ctl_pin(shared_ctl_pin),
  .spi_miso_reg(spi_miso_reg), .spi_miso_oe_reg(spi_miso_oe_reg),
  .write_busy_reg(write_busy_reg), .array_start_reg(array_start_reg),
  .array_kind_reg(array_kind_reg), .array_otp_reg(array_otp_reg),
  .array_addr_reg(array_addr_reg), .pause_active_reg(pause_active_reg),
  .hw_restart_reg(hw_restart_reg));

// ### tb_top.sv
// Purpose: Self-checking bench of the flash status and protection block
// Assumes: Busy lengthened to 300 cycles so reads fit inside it
// Notes: Host model frames every command; starts logged by a monitor
`timescale 1ns/1ps
module tb_top;
  localparam OPC = 300;
  reg sys_clk, resetn, guard, shpin, s_otp, in_otp;
  reg [7:0] rd, v;
  reg [2:0] s_kind;
  reg [23:0] s_addr;
  wire sclk, cs_n, mosi, miso, busy, start, pause_o, rst_o, otp_o;
  wire [2:0] kind;
  wire [23:0] addr;
  integer n_fail, n_compared, seed, cyc, n_start, i;
  fsp_host_model host (.sys_clk(sys_clk), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  fsp_status_protect #(.OP_CYCLES(OPC), .BLK_BITS(7)) uut (.sys_clk(sys_clk),
    .resetn(resetn), .spi_clk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .write_guard_pin(guard), .shared_ctl_pin(shpin), .spi_miso_reg(miso),
    .spi_miso_oe_reg(), .write_busy_reg(busy), .array_start_reg(start),
    .array_kind_reg(kind), .array_otp_reg(otp_o), .array_addr_reg(addr),
    .pause_active_reg(pause_o), .hw_restart_reg(rst_o));
  // ------------------------------------------------------------
  // Clock, monitor and tasks
  // ------------------------------------------------------------
  always #4 sys_clk = ~sys_clk;
  // Logs array starts; ceiling cuts a hang short
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (start === 1'b1) begin
      n_start = n_start + 1;
      s_kind = kind;
      s_addr = addr;
      s_otp = otp_o;
    end
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      tally_and_finish;
    end
  end
  task check(input [23:0] seen, input [23:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  // Waits out any busy window, bounded
  task op(input [47:0] d, input integer n);
    integer k;
    begin
      host.xfer(d, n, rd);
      k = 0;
      repeat (4) @(posedge sys_clk);
      while (busy !== 1'b0 && k < 2000) begin
        @(posedge sys_clk);
        k = k + 1;
      end
      #1;
    end
  endtask
  task stat(input [7:0] exp);
    begin
      host.xfer({8'h05, 8'h00}, 16, rd);
      check(rd, exp);
    end
  endtask
  task wr(input [7:0] d);
    begin
      op(8'h06, 8);
      op({8'h01, d}, 16);
    end
  endtask
  // k of zero means the command must be refused
  task wipe(input [47:0] d, input integer n, input [2:0] k, input [23:0] a);
    integer b;
    begin
      b = n_start;
      op(8'h06, 8);
      op(d, n);
      check(n_start - b, k != 3'h0);
      if (k != 3'h0) begin
        check(s_kind, k);
        check(s_addr, a);
        check(s_otp, in_otp);
      end
    end
  endtask
  task pin(input ep, input er);
    begin
      shpin = 1'b0;
      repeat (6) @(posedge sys_clk) #1;
      check(pause_o, ep);
      check(rst_o, er);
      shpin = 1'b1;
      repeat (6) @(posedge sys_clk) #1;
    end
  endtask
  task tally_and_finish;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
        $display("Run complete: PASS");
      end else begin
        $display("Run complete: FAIL");
      end
      $finish;
    end
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    guard = 1'b0; // Low guard is ignored while pin functions are off
    shpin = 1'b1;
    n_fail = 0;
    n_compared = 0;
    cyc = 0;
    n_start = 0;
    in_otp = 1'b0;
    seed = 84241;
    repeat (10) @(posedge sys_clk) #1;
    resetn = 1'b1;
    repeat (5) @(posedge sys_clk) #1;
    stat(8'h00);
    op(8'h3A, 8);
    stat(8'h40);
    op(8'h04, 8);
    stat(8'h00);
    op({8'h01, 8'h3C}, 16);
    stat(8'h00);
    op(8'h06, 8);
    stat(8'h02);
    // Reads during busy, then random field values incl. indicator bits
    for (i = 0; i < 3; i = i + 1) begin
      v = $random(seed);
      if (i == 0) v[7] = 1'b1; // Lock set early so the ignored guard pin is exercised
      op(8'h06, 8);
      host.xfer({8'h01, v}, 16, rd);
      host.xfer({8'h05, 8'h00}, 16, rd);
      check(rd[0], 1'b1);
      host.xfer({8'h09, 8'h00}, 16, rd);
      check(rd, 8'h01);
      op(8'h00, 8);
      stat({v[7:2], 2'b00});
    end
    wr(8'h04);
    wipe({8'h20, 24'h7F1000}, 32, 3'h0, 24'h0);
    wipe({8'h02, 24'h7F0000, 8'hA5}, 40, 3'h0, 24'h0);
    wipe({8'h20, 24'h001000}, 32, 3'h2, 24'h001000);
    wipe(8'hC7, 8, 3'h0, 24'h0);
    wr(8'h00);
    wipe(8'hC7, 8, 3'h4, 24'h000000);
    wr(8'h40);
    wipe(8'hC7, 8, 3'h0, 24'h0);
    wipe({8'h20, 24'h7F0000}, 32, 3'h0, 24'h0);
    wipe({8'hD8, 24'h7E0000}, 32, 3'h3, 24'h7E0000);
    op(8'h3A, 8);
    wr(8'h1C);
    stat(8'h18);
    op(8'h04, 8);
    stat(8'h40);
    wipe({8'h20, 24'h000000}, 32, 3'h0, 24'h0);
    wipe({8'h20, 24'h001000}, 32, 3'h2, 24'h001000);
    guard = 1'b1;
    wr(8'hC0);
    guard = 1'b0;
    wr(8'h40);
    stat(8'hC2);
    guard = 1'b1;
    op({8'h01, 8'h40}, 16);
    stat(8'h40);
    pin(1'b1, 1'b0);
    op(8'h3A, 8);
    wr(8'h38);
    pin(1'b0, 1'b1);
    wipe({8'h32, 24'h002000, 8'h5A}, 40, 3'h1, 24'h002000);
    pin(1'b0, 1'b0);
    // OTP sector open until its lock is set, then closed for good
    op(8'h3A, 8);
    in_otp = 1'b1;
    wipe({8'h02, 24'h000010, 8'h3C}, 40, 3'h1, 24'h000010);
    wr(8'hB8);
    wipe({8'h20, 24'h000000}, 32, 3'h0, 24'h0);
    wr(8'h38);
    stat(8'hB8);
    tally_and_finish;
  end
endmodule // tb_top
